// ---- design/ddrc_io_cell.sv ----
/*
  ddrc_io_cell: programmable i/o cell with bypass, optional delay, sdr register,
  ddr strobe capture with polarity-selected transfer into sys_clk, output and
  tristate register sections, and a wishbone control/status slave.
  Assumes strobe_clk is the delayed strobe from the memory, that strobe_level_in
  is the raw strobe pad level, and that core control inputs run on sys_clk.
*/
// Summary of operation
// - cell has input, output, tristate and control sections; input, output and tristate are each sdr and ddr capable
// - pad input also goes straight out as combinational, clock-network and strobe-tap signals
// - sdr input path passes an optional delay stage selected by software; ddr capture samples the pad directly
// - sdr mode captures input in one synchronising register on the system clock
// - ddr mode samples on both strobe edges, both streams resynchronised to system clock
// - sdr and synchronising registers have reset and clock enable
// - polarity select chooses which system clock edge clocks the synchronising stage
// - polarity is re-evaluated at the start of every read
// - detector sees strobe fall at preamble and sets the synchronising polarity
// - registered input path captures on the rising edge of the input clock
// - separate core clock enables gate input and output section flip-flops
// - cell registers obey local set/reset and active-low global set/reset
// - output enable from one tristate signal in sdr, a pair in ddr
// - ddr delivers two registered input signals, one per captured stream
// - output takes one data signal for both modes plus a second for ddr
`timescale 1ns/1ps
module ddrc_io_cell #(
  parameter int unsigned DELAY_STAGES = 2
) (
  // system clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // link side, delayed strobe and raw strobe level
  input  wire logic       strobe_clk,
  input  wire logic       strobe_level_in,
  // pad
  input  wire logic       pad_input_signal,
  output      logic       pad_out,
  output      logic       pad_oe_n,
  // input section toward the core
  output      logic       combinational_input_path,
  output      logic       input_to_clock_network,
  output      logic       strobe_delay_input,
  output      logic       registered_input_path,
  output      logic [1:0] ddr_captured_inputs,
  output      logic       ddr_pair_valid,
  // control from the core
  input  wire logic [1:0] io_section_clock_enables,
  input  wire logic       local_set_reset,
  input  wire logic       global_set_reset_n,
  // output and tristate section from the core
  input  wire logic       output_data_primary,
  input  wire logic       output_data_second_edge,
  input  wire logic       sdr_tristate_control,
  input  wire logic [1:0] ddr_tristate_pair,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output      logic [31:0] wb_dat_o,
  output      logic        wb_ack_o,
  // status
  output      logic        sync_clock_polarity_select
);
  import ddrc_pkg::*;

  generate
    // the shift line below needs at least two stages to index its lower slice
    if (DELAY_STAGES < 2 || DELAY_STAGES > 8) begin : g_bad_delay
      $error("DELAY_STAGES must be 2..8");
    end
  endgenerate

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [CTRL_W-1:0]     ctrl_reg;
  logic                  ack_reg;
  logic                  regs_clear;
  logic                  ce_in;
  logic                  ce_out;
  logic                  ddr_mode;
  logic                  pad_sync;
  logic [DELAY_STAGES-1:0] delay_reg;
  logic                  sdr_src;
  logic                  link_rst_n;
  logic                  link_ddr_mode;
  logic                  rise_cap_reg;
  logic [1:0]            slot0_reg;
  logic [1:0]            slot1_reg;
  logic                  wr_sel_reg;
  logic                  wr_tgl_reg;
  logic [1:0]            sync_pos_out;
  logic [1:0]            sync_neg_out;
  logic                  sel_tgl;
  logic                  tgl_seen_reg;
  logic                  rd_sel_reg;
  logic                  new_pair;
  logic [1:0]            pair_mux;
  logic                  lvl_prev_reg;
  logic                  preamble_hit;
  logic                  pol_decision;
  logic                  pol_reg;
  ddrc_burst_type        burst_reg;
  logic [IDLE_CNT_W-1:0] idle_cnt_reg;
  logic [PRE_CNT_W-1:0]  pre_cnt_reg;
  logic                  out_pos_reg;
  logic                  out_neg_reg;
  logic                  tri_pos_reg;
  logic                  tri_neg_reg;
  logic                  wb_req;

  // ****************************************************************
  // control section: clock enables, set/reset, mode
  // ****************************************************************
  // input and output sections each have their own enable from the core
  assign ce_in      = io_section_clock_enables[0];
  assign ce_out     = io_section_clock_enables[1];
  // local set/reset or active-low global clears cell registers
  assign regs_clear = !nrst || !global_set_reset_n || local_set_reset;
  assign ddr_mode   = ctrl_reg[CTRL_DDR_MODE_BIT];

  // ****************************************************************
  // bypass paths
  // ****************************************************************
  // straight pad taps; these are combinational by nature of the bypass
  assign combinational_input_path = pad_input_signal;
  assign input_to_clock_network   = pad_input_signal;
  assign strobe_delay_input       = pad_input_signal;

  // ****************************************************************
  // sdr input path: pin synchroniser, optional delay, sync register
  // ****************************************************************
  ddrc_sync2 #(
    .WIDTH     (1),
    .FIRST_NEG (1'b0)
  ) u_pad_sync (
    .clk      (sys_clk),
    .rst_n    (nrst),
    .async_in (pad_input_signal),
    .sync_out (pad_sync)
  );

  // delay line trades latency for hold margin on the sdr register
  always_ff @(posedge sys_clk) begin
    if (!nrst) delay_reg <= '0;
    else       delay_reg <= {delay_reg[DELAY_STAGES-2:0], pad_sync};
  end
  assign sdr_src = ctrl_reg[CTRL_DELAY_EN_BIT] ? delay_reg[DELAY_STAGES-1] : pad_sync;

  // single sdr register on the rising edge, with enable and reset
  always_ff @(posedge sys_clk) begin
    if (regs_clear) begin
      registered_input_path <= 1'b0;
    end else if (ce_in && !ddr_mode) begin
      registered_input_path <= sdr_src;
    end
  end

  // ****************************************************************
  // strobe domain: ddr capture on both edges
  // ****************************************************************
  ddrc_sync2 #(
    .WIDTH     (2),
    .FIRST_NEG (1'b0)
  ) u_link_sync (
    .clk      (strobe_clk),
    .rst_n    (1'b1),
    .async_in ({nrst, ddr_mode}),
    .sync_out ({link_rst_n, link_ddr_mode})
  );

  // rising strobe edge sample
  always_ff @(posedge strobe_clk) begin
    if (!link_rst_n) rise_cap_reg <= 1'b0;
    else             rise_cap_reg <= pad_input_signal;
  end

  // falling edge completes a pair; two slots so each word stays put for two
  // strobe periods, longer than the sys side needs to pick it up
  always_ff @(negedge strobe_clk) begin
    if (!link_rst_n) begin
      slot0_reg  <= 2'h0;
      slot1_reg  <= 2'h0;
      wr_sel_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
    end else if (link_ddr_mode) begin
      if (wr_sel_reg) slot1_reg <= {pad_input_signal, rise_cap_reg};
      else            slot0_reg <= {pad_input_signal, rise_cap_reg};
      wr_sel_reg <= !wr_sel_reg;
      wr_tgl_reg <= !wr_tgl_reg;
    end
  end

  // ****************************************************************
  // crossing into sys_clk: one synchroniser per sys_clk edge
  // ****************************************************************
  ddrc_sync2 #(
    .WIDTH     (2),
    .FIRST_NEG (1'b0)
  ) u_sync_pos (
    .clk      (sys_clk),
    .rst_n    (nrst),
    .async_in ({strobe_level_in, wr_tgl_reg}),
    .sync_out (sync_pos_out)
  );

  ddrc_sync2 #(
    .WIDTH     (2),
    .FIRST_NEG (1'b1)
  ) u_sync_neg (
    .clk      (sys_clk),
    .rst_n    (nrst),
    .async_in ({strobe_level_in, wr_tgl_reg}),
    .sync_out (sync_neg_out)
  );

  // polarity picks which edge's synchroniser feeds the transfer
  assign sel_tgl  = pol_reg ? sync_neg_out[0] : sync_pos_out[0];
  assign new_pair = (sel_tgl != tgl_seen_reg);
  assign pair_mux = rd_sel_reg ? slot1_reg : slot0_reg;

  // both words land in the same cycle so the core sees an aligned pair
  always_ff @(posedge sys_clk) begin
    if (regs_clear) begin
      ddr_captured_inputs <= 2'h0;
      ddr_pair_valid      <= 1'b0;
    end else if (new_pair && ce_in && ddr_mode) begin
      ddr_captured_inputs <= pair_mux;
      ddr_pair_valid      <= 1'b1;
    end else begin
      ddr_pair_valid      <= 1'b0;
    end
  end

  // read side bookkeeping follows the toggle even when disabled, so a stalled
  // enable drops pairs instead of misaligning slots
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tgl_seen_reg <= 1'b0;
      rd_sel_reg   <= 1'b0;
    end else if (new_pair) begin
      tgl_seen_reg <= sel_tgl;
      rd_sel_reg   <= !rd_sel_reg;
    end
  end

  // ****************************************************************
  // preamble detection and polarity choice
  // ****************************************************************
  // strobe idles high by termination; first low seen by either edge is the
  // preamble start
  assign preamble_hit = ddr_mode && (burst_reg == BURST_IDLE) && lvl_prev_reg &&
                        (!sync_pos_out[1] || !sync_neg_out[1]);
  // rising edge saw it first: transition sits near that edge, use falling
  assign pol_decision = ctrl_reg[CTRL_POL_AUTO_BIT] ? (!sync_pos_out[1] && sync_neg_out[1])
                                                    : ctrl_reg[CTRL_POL_MANUAL_BIT];

  always_ff @(posedge sys_clk) begin
    if (!nrst) lvl_prev_reg <= 1'b0;
    else       lvl_prev_reg <= sync_pos_out[1] && sync_neg_out[1];
  end

  // latched only at the preamble; held for the whole burst
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pol_reg <= 1'b0;
    end else if (preamble_hit) begin
      pol_reg <= pol_decision;
    end
  end
  assign sync_clock_polarity_select = pol_reg;

  // burst tracking: ends after a quiet spell with no pairs
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      burst_reg    <= BURST_IDLE;
      idle_cnt_reg <= '0;
      pre_cnt_reg  <= '0;
    end else begin
      case (burst_reg)
        BURST_IDLE: begin
          idle_cnt_reg <= '0;
          if (preamble_hit) begin
            burst_reg   <= BURST_ACTIVE;
            pre_cnt_reg <= pre_cnt_reg + 1'b1;
          end
        end
        BURST_ACTIVE: begin
          if (new_pair) begin
            idle_cnt_reg <= '0;
          end else if (idle_cnt_reg == IDLE_CNT_W'(BURST_IDLE_CYC - 1)) begin
            burst_reg    <= BURST_IDLE;
            idle_cnt_reg <= '0;
          end else begin
            idle_cnt_reg <= idle_cnt_reg + 1'b1;
          end
        end
        default: begin
          burst_reg    <= BURST_IDLE;
          idle_cnt_reg <= '0;
        end
      endcase
    end
  end

  // ****************************************************************
  // output and tristate register sections
  // ****************************************************************
  // rising-edge half carries primary data / first tristate control
  always_ff @(posedge sys_clk) begin
    if (regs_clear) begin
      out_pos_reg <= 1'b0;
      tri_pos_reg <= 1'b1;
    end else if (ce_out) begin
      out_pos_reg <= output_data_primary;
      tri_pos_reg <= ddr_mode ? ddr_tristate_pair[0] : sdr_tristate_control;
    end
  end

  // falling-edge half for the ddr second edge
  always_ff @(negedge sys_clk) begin
    if (regs_clear) begin
      out_neg_reg <= 1'b0;
      tri_neg_reg <= 1'b1;
    end else if (ce_out) begin
      out_neg_reg <= output_data_second_edge;
      tri_neg_reg <= ddr_tristate_pair[1];
    end
  end

  // ddr mux on the clock level; sdr uses the rising half only
  assign pad_out  = (ddr_mode && !sys_clk) ? out_neg_reg : out_pos_reg;
  assign pad_oe_n = (ddr_mode && !sys_clk) ? tri_neg_reg : tri_pos_reg;

  // ****************************************************************
  // wishbone slave: one wait state, unmapped reads zero
  // ****************************************************************
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;

  always_ff @(posedge sys_clk) begin
    if (!nrst) ack_reg <= 1'b0;
    else       ack_reg <= wb_req;
  end
  assign wb_ack_o = ack_reg;

  // control register steers mode, delay and polarity policy
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFFSET) begin
      ctrl_reg <= wb_dat_i[CTRL_W-1:0];
    end
  end

  // read data registered alongside ack
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0;
    end else if (wb_req && !wb_we_i) begin
      wb_dat_o <= 32'h0;
      case (wb_adr_i)
        CTRL_OFFSET: wb_dat_o[CTRL_W-1:0] <= ctrl_reg;
        STAT_OFFSET: begin
          wb_dat_o[STAT_POL_BIT]   <= pol_reg;
          wb_dat_o[STAT_BURST_BIT] <= (burst_reg == BURST_ACTIVE);
          wb_dat_o[STAT_PRE_CNT_LSB +: PRE_CNT_W] <= pre_cnt_reg;
        end
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_sdr_capture: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce_in && !ddr_mode && global_set_reset_n && !local_set_reset)
    |=> registered_input_path == $past(sdr_src))
    else $error("sdr register did not capture its source");

  a_ce_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!ce_in && global_set_reset_n && !local_set_reset)
    |=> $stable(registered_input_path) && $stable(ddr_captured_inputs))
    else $error("input register changed while disabled");

  a_gsr_clears: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!global_set_reset_n || local_set_reset)
    |=> !registered_input_path && ddr_captured_inputs == 2'h0 && !out_pos_reg)
    else $error("set/reset did not clear the cell registers");

  a_pair_aligned: assert property (@(posedge sys_clk) disable iff (!nrst)
    (new_pair && ce_in && ddr_mode && global_set_reset_n && !local_set_reset)
    |=> ddr_pair_valid && ddr_captured_inputs == $past(pair_mux))
    else $error("ddr pair not delivered together");

  a_pol_latched: assert property (@(posedge sys_clk) disable iff (!nrst)
    preamble_hit |=> pol_reg == $past(pol_decision) && burst_reg == BURST_ACTIVE)
    else $error("polarity not taken at preamble");

  a_pol_stable: assert property (@(posedge sys_clk) disable iff (!nrst)
    !preamble_hit |=> $stable(pol_reg))
    else $error("polarity changed outside a preamble");

  a_oe_sdr: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ce_out && !ddr_mode && global_set_reset_n && !local_set_reset) ##1 !ddr_mode
    |-> tri_pos_reg == $past(sdr_tristate_control) && pad_oe_n == tri_pos_reg)
    else $error("sdr output enable not from the tristate signal");

  a_ack_pulse: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle answer");

endmodule

// ---- design/ddrc_pkg.sv ----
/*
  ddrc_pkg: shared constants for the ddr input capture i/o cell.
  Assumes a 40 MHz system clock and a 32-bit classic wishbone register bus.
*/
package ddrc_pkg;

  // ****************************************************************
  // clocking and timing
  // ****************************************************************
  localparam int unsigned SYS_CLK_MHZ    = 40;
  // burst ends when no pair arrives for this long
  localparam int unsigned BURST_IDLE_NS  = 500;
  localparam int unsigned BURST_IDLE_CYC = (BURST_IDLE_NS * SYS_CLK_MHZ) / 1000;
  localparam int unsigned IDLE_CNT_W     = 8;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h04;

  // control register fields
  localparam int unsigned CTRL_DDR_MODE_BIT   = 0;
  localparam int unsigned CTRL_DELAY_EN_BIT   = 1;
  localparam int unsigned CTRL_POL_AUTO_BIT   = 2;
  localparam int unsigned CTRL_POL_MANUAL_BIT = 3;
  localparam int unsigned CTRL_W              = 4;
  localparam logic [3:0]  CTRL_RESET          = 4'h4;

  // status register fields
  localparam int unsigned STAT_POL_BIT        = 0;
  localparam int unsigned STAT_BURST_BIT      = 1;
  localparam int unsigned STAT_PRE_CNT_LSB    = 8;
  localparam int unsigned PRE_CNT_W           = 8;

  // ****************************************************************
  // read burst tracking states
  // ****************************************************************
  typedef enum logic [1:0] {
    BURST_IDLE   = 2'b01,
    BURST_ACTIVE = 2'b10
  } ddrc_burst_type;

endpackage

// ---- design/ddrc_sync2.sv ----
/*
  ddrc_sync2: two flip-flop level synchroniser, optional falling-edge first stage.
  Assumes the input is a level that stays put long enough to be sampled twice.
*/
`timescale 1ns/1ps
module ddrc_sync2 #(
  parameter int unsigned WIDTH     = 1,
  parameter bit          FIRST_NEG = 1'b0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // ****************************************************************
  // first stage, edge chosen at elaboration
  // ****************************************************************
  generate
    if (FIRST_NEG) begin : g_neg
      always_ff @(negedge clk) begin
        if (!rst_n) meta_reg <= '0;
        else        meta_reg <= async_in;
      end
    end else begin : g_pos
      always_ff @(posedge clk) begin
        if (!rst_n) meta_reg <= '0;
        else        meta_reg <= async_in;
      end
    end
  endgenerate

  // second stage, only reader of the first
  always_ff @(posedge clk) begin
    if (!rst_n) sync_out <= '0;
    else        sync_out <= meta_reg;
  end

endmodule

// ---- testbench/ddrc_io_cell_test.sv ----
/*
  ddrc_io_cell_test: directed bench for the ddr input capture cell.
  Assumes ddrc_mem_model on the strobe side and the package register map.
*/
`timescale 1ns/1ps
module ddrc_io_cell_test;
  import ddrc_pkg::*;
  localparam int DS = 2;
  logic        sys_clk, nrst, strobe_clk, strobe_level_in, pad_input_signal, pad_out, pad_oe_n;
  logic        combinational_input_path, input_to_clock_network, strobe_delay_input, registered_input_path;
  logic [1:0]  ddr_captured_inputs, io_section_clock_enables, ddr_tristate_pair;
  logic        ddr_pair_valid, local_set_reset, global_set_reset_n, output_data_primary;
  logic        output_data_second_edge, sdr_tristate_control, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, burst_data;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        sync_clock_polarity_select, read_req, burst_done, pad_data, tb_pad, sdr_sel;
  logic [1:0]  got_q[$];
  logic        pol_q[$];
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;

  ddrc_io_cell #(.DELAY_STAGES(DS)) i_dut (.sys_clk, .nrst, .strobe_clk, .strobe_level_in,
    .pad_input_signal, .pad_out, .pad_oe_n, .combinational_input_path, .input_to_clock_network,
    .strobe_delay_input, .registered_input_path, .ddr_captured_inputs, .ddr_pair_valid,
    .io_section_clock_enables, .local_set_reset, .global_set_reset_n, .output_data_primary,
    .output_data_second_edge, .sdr_tristate_control, .ddr_tristate_pair, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sync_clock_polarity_select);
  ddrc_mem_model i_mem (.rst_n(nrst), .read_req, .burst_data, .strobe_clk, .strobe_level_in,
    .pad_data, .burst_done);
  // sdr tests own the pad, ddr reads hand it to the memory
  assign pad_input_signal = sdr_sel ? tb_pad : pad_data;

  // ****************************************************************
  // clock, pair monitor, timeout
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // pairs are recorded with the polarity in force when they land
  always @(posedge sys_clk) begin
    cyc++;
    if (ddr_pair_valid === 1'b1) begin
      got_q.push_back(ddr_captured_inputs);
      pol_q.push_back(sync_clock_polarity_select);
    end
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  // classic single wishbone cycle; the wait is bounded so a dead slave cannot hang us
  task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      tick(1);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (n >= 50) chk("ack", 1, 0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    tick(1);
  endtask
  // one read burst; the long tail lets the burst tracker go idle again
  task automatic burst(input logic [7:0] d, input int np, input logic ep);
    int n;
    n = 0;
    got_q.delete();
    pol_q.delete();
    burst_data <= d;
    read_req <= 1'b1;
    do begin
      tick(1);
      n++;
    end while (burst_done !== 1'b1 && n < 200);
    read_req <= 1'b0;
    tick(40);
    chk("pair count", np, got_q.size());
    for (int i = 0; i < got_q.size(); i++) begin
      chk("ddr pair", {d[2*i+1], d[2*i]}, got_q[i]);
      chk("burst polarity", (ep === 1'bx) ? pol_q[0] : ep, pol_q[i]);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {nrst, local_set_reset, output_data_primary, output_data_second_edge, read_req, tb_pad} = '0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, burst_data} = '0;
    {global_set_reset_n, sdr_tristate_control, sdr_sel} = 3'b111;
    {io_section_clock_enables, ddr_tristate_pair, wb_sel_i} = 8'hff;
    tick(12);
    nrst <= 1'b1;
    tick(1);
    #1 chk("reset outputs", 4'h1, {registered_input_path, ddr_captured_inputs, pad_oe_n});
    wb_io(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl reset", 32'h4, rd);
    wb_io(1'b0, STAT_OFFSET, 32'h0);
    chk("stat reset", 32'h0, rd);
    wb_io(1'b0, 8'h08, 32'h0);
    chk("unmapped read", 32'h0, rd);
    tb_pad <= 1'b1;
    tick(2);
    #1 chk("bypass taps", 3'h7, {combinational_input_path, input_to_clock_network, strobe_delay_input});
    chk("sdr early", 0, registered_input_path);
    tick(1);
    #1 chk("sdr capture", 1, registered_input_path);
    tick(1);
    wb_io(1'b1, CTRL_OFFSET, 32'h2);
    tb_pad <= 1'b0;
    tick(2 + DS);
    #1 chk("delay early", 1, registered_input_path);
    tick(1);
    #1 chk("delay capture", 0, registered_input_path);
    tick(1);
    io_section_clock_enables <= 2'b10;
    tb_pad <= 1'b1;
    tick(8);
    #1 chk("ce0 hold", 0, registered_input_path);
    tick(1);
    io_section_clock_enables <= 2'b11;
    tick(8);
    local_set_reset <= 1'b1;
    tick(1);
    #1 chk("local clear", 0, registered_input_path);
    tick(1);
    local_set_reset <= 1'b0;
    tick(8);
    global_set_reset_n <= 1'b0;
    tick(1);
    #1 chk("global clear", 0, registered_input_path);
    tick(1);
    global_set_reset_n <= 1'b1;
    output_data_primary <= 1'b1;
    sdr_tristate_control <= 1'b0;
    tick(2);
    #1 chk("sdr out", 2'b10, {pad_out, pad_oe_n});
    tick(1);
    io_section_clock_enables <= 2'b01;
    output_data_primary <= 1'b0;
    tick(3);
    #1 chk("ce1 hold", 1, pad_out);
    tick(1);
    io_section_clock_enables <= 2'b11;
    output_data_primary <= 1'b1;
    ddr_tristate_pair <= 2'b00;
    wb_io(1'b1, CTRL_OFFSET, 32'h9);
    sdr_sel <= 1'b0;
    tick(3);
    #3 chk("ddr out high half", 2'b10, {pad_out, pad_oe_n});
    @(negedge sys_clk);
    #3 chk("ddr out low half", 2'b00, {pad_out, pad_oe_n});
    tick(1);
    io_section_clock_enables <= 2'b10;
    burst(8'ha5, 0, 1'b1);
    io_section_clock_enables <= 2'b11;
    burst(8'h6c, 4, 1'b1);
    wb_io(1'b0, STAT_OFFSET, 32'h0);
    chk("stat manual one", 32'h0201, rd);
    chk("polarity port", 1, sync_clock_polarity_select);
    wb_io(1'b1, CTRL_OFFSET, 32'h1);
    burst(8'h93, 4, 1'b0);
    wb_io(1'b0, STAT_OFFSET, 32'h0);
    chk("stat manual zero", 32'h0300, rd);
    wb_io(1'b1, CTRL_OFFSET, 32'h5);
    burst(8'h3a, 4, 1'bx);
    wb_io(1'b0, STAT_OFFSET, 32'h0);
    chk("preamble count", 8'h04, rd[15:8]);
    wb_io(1'b1, STAT_OFFSET, 32'hffff);
    wb_sel_i <= 4'h0;
    wb_io(1'b1, CTRL_OFFSET, 32'h0);
    wb_sel_i <= 4'hf;
    wb_io(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl kept", 32'h5, rd);
    close_out();
  end
endmodule

// ---- testbench/ddrc_mem_model.sv ----
/*
  ddrc_mem_model: behavioural read side of a ddr memory, strobe and data pin.
  Assumes the bench raises read_req, waits for burst_done, then drops read_req.
*/
`timescale 1ns/1ps
module ddrc_mem_model (
  // control from the bench
  input  wire logic       rst_n,
  input  wire logic       read_req,
  input  wire logic [7:0] burst_data,
  // memory pins
  output      logic       strobe_clk,
  output      logic       strobe_level_in,
  output      logic       pad_data,
  output      logic       burst_done
);
  // ****************************************************************
  // read bursts
  // ****************************************************************
  // strobe runs during reset so the link-side reset lands; it stands still between reads
  initial begin
    strobe_clk = 1'b0;
    strobe_level_in = 1'b1;
    pad_data = 1'b0;
    burst_done = 1'b0;
    #7;
    forever begin
      if (!rst_n) begin
        #32 strobe_clk = ~strobe_clk;
      end else if (read_req && !burst_done) begin
        strobe_level_in = 1'b0;
        #64;
        for (int i = 0; i < 4; i++) begin
          pad_data = burst_data[2*i];
          #16 strobe_clk = 1'b1;
          #16 pad_data = burst_data[2*i+1];
          #16 strobe_clk = 1'b0;
          #16;
        end
        strobe_level_in = 1'b1;
        burst_done = 1'b1;
      end else begin
        burst_done = burst_done & read_req;
        strobe_clk = 1'b0;
        // released data line keeps moving so a stale bit cannot pass
        #32 pad_data = ~pad_data;
      end
    end
  end
endmodule
